// ==== host_side_model.sv ====
// Purpose: Host controller model that starts read bursts and sends wake pulses to the configuration bank.
// Assumes: All outputs change by non-blocking assignment right after a rising clock edge.
// Notes: Every address seen during a burst is kept in a queue for the bench to compare.
`timescale 1ns/1ps
module host_side_model (
  input wire logic clk,
  input wire logic [31:0] burst_addr,
  output logic burst_start,
  output logic [31:0] burst_start_addr,
  output logic burst_advance,
  output logic cs_pulse,
  output logic hw_reset_req
);
  logic [31:0] seen [$]; // Addresses observed during the last burst.

  // All host outputs are quiet at time zero.
  initial
  begin
    burst_start = 1'b0;
    burst_start_addr = 32'h0;
    burst_advance = 1'b0;
    cs_pulse = 1'b0;
    hw_reset_req = 1'b0;
  end

  // Starts a burst at s and then steps n times back to back, logging each address.
  task automatic run_burst(input logic [31:0] s, input int n);
    seen.delete();
    @(posedge clk);
    burst_start <= 1'b1;
    burst_start_addr <= s;
    @(posedge clk);
    burst_start <= 1'b0;
    burst_advance <= (n > 0);
    #1 seen.push_back(burst_addr);
    for (int i = 1; i <= n; i++)
    begin
      @(posedge clk);
      if (i == n)
        burst_advance <= 1'b0;
      #1 seen.push_back(burst_addr);
    end
  endtask

  // Sends one wake pulse: kind 0 is a chip-select pulse, kind 1 a hardware reset request.
  task automatic wake(input int kind);
    @(posedge clk);
    if (kind == 0)
      cs_pulse <= 1'b1;
    else
      hw_reset_req <= 1'b1;
    @(posedge clk);
    cs_pulse <= 1'b0;
    hw_reset_req <= 1'b0;
    #1;
  endtask
endmodule

// ==== read_wrap_ecc_power_config.sv ====
// Purpose: Persistent and live configuration copies, wrap address stepping, power state and ECC bookkeeping.
// Assumes: All inputs except the asynchronous rst are synchronous to clk; persistent storage is modelled by flip-flops.
// Notes: Read data stand only in the cycle after a read strobe and read zero otherwise.
//
// Our own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "wrap_cfg_params.svh"

module read_wrap_ecc_power_config (
  input wire logic clk,
  input wire logic rst,
  input wire wrap_cfg_pkg::reg_req_t reg_req,
  output logic [31:0] rdata,
  input wire logic cs_pulse,
  input wire logic hw_reset_req,
  input wire logic burst_start,
  input wire logic [31:0] burst_start_addr,
  input wire logic burst_advance,
  output logic [31:0] burst_addr,
  output logic wrap_active,
  output logic [7:0] drive_ohms,
  output logic deep_sleep_state,
  output logic config_ready,
  input wire logic ecc_corrected,
  input wire logic ecc_double,
  input wire logic [31:0] ecc_addr,
  output logic ecc_uncorrectable
);

  // Decodes a drive strength code into output impedance in ohms.
  function automatic logic [7:0] ohms_of(input logic [2:0] code);
    logic [7:0] r;
    r = 8'h2D;
    unique case (code)
      3'h0: r = 8'h2D;
      3'h1: r = 8'h78;
      3'h2: r = 8'h5A;
      3'h3: r = 8'h3C;
      3'h4: r = 8'h2D;
      3'h5: r = 8'h1E;
      3'h6: r = 8'h14;
      3'h7: r = 8'h0F;
    endcase
    return r;
  endfunction

  // Mask of the offset bits inside one wrap group.
  function automatic logic [31:0] wrap_mask(input logic [1:0] len);
    return (32'h0000_0008 << len) - 32'h0000_0001;
  endfunction

  // Next burst address, wrapping inside the aligned group when enabled.
  function automatic logic [31:0] step_addr(input logic [31:0] a, input logic en, input logic [1:0] len);
    logic [31:0] m;
    logic [31:0] inc;
    m = wrap_mask(len);
    inc = a + 32'h0000_0001;
    if (en)
    begin
      return (a & ~m) | (inc & m);
    end
    return inc;
  endfunction

  // Persistent copy; reset stands for the factory programmed value.
  wrap_cfg_pkg::cfg_t persist_reg;
  // Live working copy that steers the block.
  wrap_cfg_pkg::cfg_t live_reg;
  // Power state of the device.
  wrap_cfg_pkg::power_state_t state_reg;
  // Burst address currently delivered.
  logic [31:0] burst_addr_reg;
  // Wrap mode latched when the current burst started.
  logic wrap_active_reg;
  logic [1:0] wrap_len_reg;
  // Burst in progress flag.
  logic burst_busy_reg;
  // Read data register.
  logic [31:0] rdata_reg;
  // ECC error counter and trapped address.
  logic [`ERR_COUNT_W-1:0] err_count_reg;
  logic [31:0] trap_addr_reg;
  logic trap_valid_reg;
  logic ecc_uncorr_reg;
  // Registered view of impedance.
  logic [7:0] drive_ohms_reg;
  // Registered power flags, so that these outputs come straight from flip-flops.
  logic deep_sleep_reg;
  logic config_ready_reg;
  // Value taken by the load: a persistent write in the load cycle is carried along.
  wrap_cfg_pkg::cfg_t load_src;

  // Decoded register port strobes.
  logic wr_persist;
  logic wr_live;
  logic wr_count;
  logic wr_trap;
  // ECC events that the current mode reports.
  logic ecc_report;
  logic ecc_double_seen;

  assign wr_persist = reg_req.wr && reg_req.addr == `IDX_PERSIST;
  assign wr_live = reg_req.wr && reg_req.addr == `IDX_LIVE && state_reg != wrap_cfg_pkg::ST_LOAD;
  assign wr_count = reg_req.wr && reg_req.addr == `IDX_ERR_COUNT;
  assign wr_trap = reg_req.wr && reg_req.addr == `IDX_TRAP_ADDR;
  // Double errors are only reported when the double detect mode is chosen.
  assign ecc_double_seen = ecc_double && live_reg.ecc_mode_select;
  assign ecc_report = ecc_corrected || ecc_double_seen;
  // Forwarding lets a persistent write at the first edge after reset pick the power-up state.
  assign load_src = wr_persist ? wrap_cfg_pkg::cfg_t'(reg_req.wdata[7:0]) : persist_reg;

  // Persistent copy takes software writes; the host rewrites the array after an ECC change.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      persist_reg <= `CFG_DEFAULT;
    end
    else if (wr_persist)
    begin
      persist_reg <= reg_req.wdata[7:0];
    end
  end

  // Live copy loads from persistent in the load state with wrap enable cleared, then follows software writes.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      live_reg <= `CFG_DEFAULT;
    end
    else if (state_reg == wrap_cfg_pkg::ST_LOAD)
    begin
      live_reg <= load_src;
      live_reg.wrap_burst_enable <= 1'b0;
    end
    else if (wr_live)
    begin
      live_reg.drive_strength_code <= reg_req.wdata[`FLD_DRIVE_HI:`FLD_DRIVE_LO];
      live_reg.wrap_burst_enable <= reg_req.wdata[`FLD_WRAP_EN];
      live_reg.ecc_mode_select <= reg_req.wdata[`FLD_ECC_MODE];
      live_reg.wrap_burst_length <= reg_req.wdata[1:0];
      // The sleep selection bit of the live copy is read-only.
    end
  end

  // Power state: load first, then standby or deep sleep as chosen; the flags move with the state.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= wrap_cfg_pkg::ST_LOAD;
      deep_sleep_reg <= 1'b0;
      config_ready_reg <= 1'b0;
    end
    else
    begin
      unique case (state_reg)
        wrap_cfg_pkg::ST_LOAD:
        begin
          // Choice follows the value that is being copied into the live copy this cycle.
          state_reg <= load_src.sleep_after_powerup ? wrap_cfg_pkg::ST_DEEP : wrap_cfg_pkg::ST_STANDBY;
          deep_sleep_reg <= load_src.sleep_after_powerup;
          config_ready_reg <= 1'b1;
        end
        wrap_cfg_pkg::ST_DEEP:
        begin
          // Chip select pulse or hardware reset wakes the device.
          if (cs_pulse || hw_reset_req)
          begin
            state_reg <= wrap_cfg_pkg::ST_STANDBY;
            deep_sleep_reg <= 1'b0;
          end
        end
        wrap_cfg_pkg::ST_STANDBY:
        begin
          state_reg <= wrap_cfg_pkg::ST_STANDBY;
        end
        default:
        begin
          // An illegal code falls back to loading.
          state_reg <= wrap_cfg_pkg::ST_LOAD;
          deep_sleep_reg <= 1'b0;
          config_ready_reg <= 1'b0;
        end
      endcase
    end
  end

  // Burst address generator; wrap mode is taken when a burst starts.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      burst_addr_reg <= 32'h0000_0000;
      wrap_active_reg <= 1'b0;
      wrap_len_reg <= 2'h0;
      burst_busy_reg <= 1'b0;
    end
    else if (state_reg != wrap_cfg_pkg::ST_STANDBY)
    begin
      // No reads are served while loading or asleep.
      burst_busy_reg <= 1'b0;
    end
    else if (burst_start)
    begin
      burst_addr_reg <= burst_start_addr;
      wrap_active_reg <= live_reg.wrap_burst_enable;
      wrap_len_reg <= live_reg.wrap_burst_length;
      burst_busy_reg <= 1'b1;
    end
    else if (burst_advance && burst_busy_reg)
    begin
      burst_addr_reg <= step_addr(burst_addr_reg, wrap_active_reg, wrap_len_reg);
    end
  end

  // ECC counter and address trap; counting wins over a clear in the same cycle.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      err_count_reg <= '0;
      trap_addr_reg <= 32'h0000_0000;
      trap_valid_reg <= 1'b0;
      ecc_uncorr_reg <= 1'b0;
    end
    else
    begin
      ecc_uncorr_reg <= ecc_double_seen;
      if (ecc_report)
      begin
        err_count_reg <= err_count_reg + `ERR_COUNT_W'(1);
      end
      else if (wr_count)
      begin
        err_count_reg <= '0;
      end
      // First reported error address is held until software clears it; an event beside the clear re-arms it.
      if (ecc_report && (!trap_valid_reg || wr_trap))
      begin
        trap_addr_reg <= ecc_addr;
        trap_valid_reg <= 1'b1;
      end
      else if (wr_trap)
      begin
        trap_valid_reg <= 1'b0;
      end
    end
  end

  // Read data stand for one cycle after a read strobe; unmapped indices read zero.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rdata_reg <= 32'h0000_0000;
    end
    else if (reg_req.rd)
    begin
      unique case (reg_req.addr)
        `IDX_PERSIST: rdata_reg <= {24'h00_0000, persist_reg};
        `IDX_LIVE: rdata_reg <= {24'h00_0000, live_reg};
        `IDX_STATUS: rdata_reg <= {29'h0000_0000, trap_valid_reg, state_reg};
        `IDX_ERR_COUNT: rdata_reg <= {16'h0000, err_count_reg};
        `IDX_TRAP_ADDR: rdata_reg <= trap_addr_reg;
        default: rdata_reg <= 32'h0000_0000;
      endcase
    end
    else
    begin
      rdata_reg <= 32'h0000_0000;
    end
  end

  // Output impedance follows the live drive code.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      drive_ohms_reg <= 8'h1E;
    end
    else
    begin
      drive_ohms_reg <= ohms_of(live_reg.drive_strength_code);
    end
  end

  assign rdata = rdata_reg;
  assign burst_addr = burst_addr_reg;
  assign wrap_active = wrap_active_reg;
  assign drive_ohms = drive_ohms_reg;
  assign deep_sleep_state = deep_sleep_reg;
  assign config_ready = config_ready_reg;
  assign ecc_uncorrectable = ecc_uncorr_reg;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // A wrapped step from the top of an 8-byte group.
  sequence s_wrap8_top;
    burst_busy_reg && burst_advance && !burst_start && state_reg == wrap_cfg_pkg::ST_STANDBY
      && wrap_active_reg && wrap_len_reg == 2'h0 && burst_addr_reg[2:0] == 3'h7;
  endsequence

  // The group base must come back after it.
  sequence s_group_base;
    burst_addr_reg[2:0] == 3'h0 && burst_addr_reg[31:3] == $past(burst_addr_reg[31:3]);
  endsequence

  AST_WRAP8_RETURNS: assert property (s_wrap8_top |=> s_group_base)
    else $error("Eight byte wrap did not return to group base.");

  AST_WRAP_STAYS_ALIGNED: assert property (
    (burst_busy_reg && burst_advance && !burst_start && wrap_active_reg && state_reg == wrap_cfg_pkg::ST_STANDBY)
      |=> ((burst_addr_reg & ~wrap_mask(wrap_len_reg)) == ($past(burst_addr_reg) & ~wrap_mask(wrap_len_reg))))
    else $error("Wrapped burst left its aligned group.");

  AST_LINEAR_STEP: assert property (
    (burst_busy_reg && burst_advance && !burst_start && !wrap_active_reg && state_reg == wrap_cfg_pkg::ST_STANDBY)
      |=> burst_addr_reg == $past(burst_addr_reg) + 32'h0000_0001)
    else $error("Unwrapped burst did not step by one.");

  AST_WRAP_TAKEN: assert property (
    (burst_start && state_reg == wrap_cfg_pkg::ST_STANDBY)
      |=> wrap_active_reg == $past(live_reg.wrap_burst_enable) && wrap_len_reg == $past(live_reg.wrap_burst_length))
    else $error("Burst did not take wrap settings from live copy.");

  AST_LOAD_COPIES: assert property (
    (state_reg == wrap_cfg_pkg::ST_LOAD)
      |=> live_reg[7:5] == persist_reg[7:5] && live_reg[3:0] == persist_reg[3:0] && !live_reg[4])
    else $error("Live copy not loaded from persistent copy.");

  AST_POWERUP_SLEEP: assert property (
    (state_reg == wrap_cfg_pkg::ST_LOAD) |=> deep_sleep_state == persist_reg.sleep_after_powerup && config_ready)
    else $error("Wrong state after load.");

  AST_WAKE: assert property (
    (state_reg == wrap_cfg_pkg::ST_DEEP && (cs_pulse || hw_reset_req)) |=> state_reg == wrap_cfg_pkg::ST_STANDBY)
    else $error("Deep sleep not left on wake request.");

  AST_SLEEP_BIT_RO: assert property (
    (state_reg != wrap_cfg_pkg::ST_LOAD) |=> $stable(live_reg.sleep_after_powerup))
    else $error("Live sleep bit changed after load.");

  AST_DRIVE_MAP: assert property (
    ##1 drive_ohms_reg == ohms_of($past(live_reg.drive_strength_code)))
    else $error("Drive impedance does not follow code.");

  AST_ECC_DOUBLE_GATED: assert property (
    (ecc_double && !live_reg.ecc_mode_select && !ecc_corrected)
      |=> !ecc_uncorr_reg && err_count_reg == ($past(wr_count) ? '0 : $past(err_count_reg)))
    else $error("Double error reported in correction-only mode.");

  AST_COUNT_WINS: assert property (
    ecc_report |=> err_count_reg == $past(err_count_reg) + `ERR_COUNT_W'(1))
    else $error("Reported ECC error not counted.");

endmodule

// ==== read_wrap_ecc_power_config_tb_top.sv ====
// Purpose: Self-checking bench for the read wrap and power configuration bank.
// Assumes: The host model drives bursts and wake pulses; the bench drives registers and ECC events.
// Notes: Outputs are sampled 1 ns after a rising edge so that all updates have landed.
`timescale 1ns/1ps
module read_wrap_ecc_power_config_tb_top;
  logic clk = 1'b0; // Bench clock, 5 ns period.
  logic rst = 1'b1; // Asynchronous reset, high at start.
  wrap_cfg_pkg::reg_req_t reg_req = '0; // Register port request.
  logic ecc_corrected = 1'b0; // Single-bit error event.
  logic ecc_double = 1'b0; // Double-bit error event.
  logic [31:0] ecc_addr = 32'h0; // Address of the error event.
  logic [31:0] rdata, burst_addr, burst_start_addr;
  logic burst_start, burst_advance, cs_pulse, hw_reset_req, wrap_active;
  logic deep_sleep_state, config_ready, ecc_uncorrectable;
  logic [7:0] drive_ohms;
  int num_errors = 0; // Mismatches seen.
  int check_count = 0; // Comparisons made.
  logic [7:0] ohms_tab [8] = '{8'h2D, 8'h78, 8'h5A, 8'h3C, 8'h2D, 8'h1E, 8'h14, 8'h0F};

  // Free-running clock.
  always #2.5 clk = ~clk;

  read_wrap_ecc_power_config uut (.clk(clk), .rst(rst), .reg_req(reg_req), .rdata(rdata),
    .cs_pulse(cs_pulse), .hw_reset_req(hw_reset_req), .burst_start(burst_start),
    .burst_start_addr(burst_start_addr), .burst_advance(burst_advance), .burst_addr(burst_addr),
    .wrap_active(wrap_active), .drive_ohms(drive_ohms), .deep_sleep_state(deep_sleep_state),
    .config_ready(config_ready), .ecc_corrected(ecc_corrected), .ecc_double(ecc_double),
    .ecc_addr(ecc_addr), .ecc_uncorrectable(ecc_uncorrectable));

  host_side_model host (.clk(clk), .burst_addr(burst_addr), .burst_start(burst_start),
    .burst_start_addr(burst_start_addr), .burst_advance(burst_advance), .cs_pulse(cs_pulse),
    .hw_reset_req(hw_reset_req));

  // Compares one value and reports a mismatch at once.
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      $display("unexpected %s expected %h seen %h", name, exp, got);
      num_errors++;
    end
  endtask

  // One-cycle register write.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: {24'h0, d}};
    @(posedge clk);
    reg_req.wr <= 1'b0;
  endtask

  // One-cycle register read; data are checked in the cycle after the strobe.
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clk);
    reg_req.rd <= 1'b0;
    #1 chk("rdata", exp, rdata);
  endtask

  // Register write with a corrected error in the same cycle; the event must win over the clear.
  task automatic wr_evt(input logic [3:0] a, input logic [31:0] ea);
    @(posedge clk);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: 32'h0};
    ecc_corrected <= 1'b1;
    ecc_addr <= ea;
    @(posedge clk);
    reg_req.wr <= 1'b0;
    ecc_corrected <= 1'b0;
  endtask

  // Reset for 20 cycles; with sleep set the persistent copy is written in the load cycle and asks for deep sleep.
  task automatic do_reset(input logic sleep);
    @(posedge clk);
    rst <= 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    if (sleep)
      reg_req <= '{wr: 1'b1, rd: 1'b0, addr: 4'h0, wdata: 32'hAC};
    @(posedge clk);
    reg_req.wr <= 1'b0;
    @(posedge clk);
    #1 chk("deep_sleep_state", {31'h0, sleep}, {31'h0, deep_sleep_state});
  endtask

  // Runs a burst and compares every address with the wrapped or linear expectation.
  task automatic burst_chk(input logic [31:0] s, input int n, input int len);
    logic [31:0] e;
    host.run_burst(s, n);
    for (int i = 0; i <= n; i++)
    begin
      e = (len == 0) ? s + i : (s & ~(len - 1)) | ((s + i) & (len - 1));
      chk("burst_addr", e, host.seen[i]);
    end
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic end_sim;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Cuts a hang short well beyond the expected run length.
  initial
  begin
    #20000;
    num_errors++;
    end_sim();
  end

  // Main test sequence.
  initial
  begin
    do_reset(1'b0);
    chk("config_ready", 32'h1, {31'h0, config_ready});
    chk("drive_ohms", 32'h1E, {24'h0, drive_ohms});
    rd(4'h0, 32'hA8);
    rd(4'h1, 32'hA8);
    rd(4'hF, 32'h0);
    // Every drive code, then a write that tries to set the read-only sleep bit.
    for (int c = 0; c < 8; c++)
    begin
      wr(4'h1, {c[2:0], 5'b01000});
      @(posedge clk);
      #1 chk("drive_ohms", {24'h0, ohms_tab[c]}, {24'h0, drive_ohms});
    end
    wr(4'h1, 8'hAC);
    rd(4'h1, 32'hA8);
    wr(4'h0, 8'h5B);
    rd(4'h0, 32'h5B);
    // Each wrap length from the last byte of its group, then a linear burst.
    for (int l = 0; l < 4; l++)
    begin
      wr(4'h1, 8'hB8 | l[7:0]);
      burst_chk(32'h100 + (8 << l) - 1, (8 << l) + 1, 8 << l);
      chk("wrap_active", 32'h1, {31'h0, wrap_active});
    end
    wr(4'h1, 8'hA8);
    burst_chk(32'h107, 2, 0);
    chk("wrap_active", 32'h0, {31'h0, wrap_active});
    // A double error is reported in the detecting mode and dropped in correction-only mode.
    @(posedge clk);
    ecc_double <= 1'b1;
    ecc_addr <= 32'h1234;
    @(posedge clk);
    ecc_double <= 1'b0;
    #1 chk("ecc_uncorrectable", 32'h1, {31'h0, ecc_uncorrectable});
    rd(4'h3, 32'h1);
    rd(4'h4, 32'h1234);
    rd(4'h2, 32'h5);
    wr(4'h1, 8'hA0); // Mode change; the array counts as rewritten before new events.
    @(posedge clk);
    ecc_double <= 1'b1;
    @(posedge clk);
    ecc_double <= 1'b0;
    #1 chk("ecc_uncorrectable", 32'h0, {31'h0, ecc_uncorrectable});
    @(posedge clk);
    ecc_corrected <= 1'b1;
    @(posedge clk);
    ecc_corrected <= 1'b0;
    rd(4'h3, 32'h2);
    // Clears beside an event: counting wins, the held trap stays, a trap clear re-arms it.
    wr_evt(4'h3, 32'h1234);
    rd(4'h3, 32'h3);
    rd(4'h4, 32'h1234);
    wr_evt(4'h4, 32'h5678);
    rd(4'h4, 32'h5678);
    rd(4'h2, 32'h5);
    wr(4'h3, 8'h00);
    rd(4'h3, 32'h0);
    wr(4'h4, 8'h00);
    rd(4'h2, 32'h1);
    // Power up into deep sleep, then wake by chip select and by hardware reset request.
    for (int k = 0; k < 2; k++)
    begin
      do_reset(1'b1);
      host.wake(k);
      chk("deep_sleep_state", 32'h0, {31'h0, deep_sleep_state});
    end
    end_sim();
  end
endmodule

// ==== wrap_cfg_params.svh ====
// Purpose: Offsets, field positions, reset values and constants of the read wrap and power configuration bank.
// Assumes: Registers are reached over a plain strobe port with 4-bit index addresses.
// Notes: Offsets are register indices on that port.
// Notes on behaviour
// - Bits 7:5 hold drive strength code.
// - Bit 4 enables wrapped read bursts.
// - Wrap mode follows enable, length bits 1:0.
// - Bits 1:0 select 8/16/32/64 byte wrap.
// - Wrapped bursts stay inside aligned group.
// - Bit 3 selects correction or double detect.
// - ECC mode steers trap and counter.
// - Bit 2 picks standby or deep sleep.
// - Chip select pulse or reset leaves sleep.
// - Eight byte wrap from 07 yields 07,00..06.
`ifndef WRAP_CFG_PARAMS_SVH
`define WRAP_CFG_PARAMS_SVH

// Register indices on the register port.
`define IDX_PERSIST 4'h0
`define IDX_LIVE 4'h1
`define IDX_STATUS 4'h2
`define IDX_ERR_COUNT 4'h3
`define IDX_TRAP_ADDR 4'h4

// Field positions inside both configuration copies.
`define FLD_DRIVE_HI 7
`define FLD_DRIVE_LO 5
`define FLD_WRAP_EN 4
`define FLD_ECC_MODE 3
`define FLD_SLEEP 2

// Factory value: drive 101, wrap off, double detect on, standby, 8 bytes.
`define CFG_DEFAULT 8'hA8

// Counter width of the ECC error counter.
`define ERR_COUNT_W 16

`endif

// ==== wrap_cfg_pkg.sv ====
// Purpose: Types shared by the read wrap and power configuration bank.
// Assumes: Used together with wrap_cfg_params.svh.
// Notes: Field order matches the bit positions of the configuration byte.
package wrap_cfg_pkg;

  // One configuration byte, most significant field first.
  typedef struct packed {
    logic [2:0] drive_strength_code;
    logic wrap_burst_enable;
    logic ecc_mode_select;
    logic sleep_after_powerup;
    logic [1:0] wrap_burst_length;
  } cfg_t;

  // One request on the register port.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [31:0] wdata;
  } reg_req_t;

  // Power state of the device.
  typedef enum logic [1:0] {
    ST_LOAD = 2'b00,
    ST_STANDBY = 2'b01,
    ST_DEEP = 2'b10
  } power_state_t;

endpackage
